// [hw/ptp_pin_select.sv]
/*
  Pin-function select for port 1 bits 0-4, pulse outputs, fast capture
  and fast event pins, timer 2 clear and clock inputs; AXI4-Lite slave.
  Assumes pin inputs synchronous to sys_clk; port 1 pins and pins 26, 27 are out/oe/in triples.
*/
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - Port 1 bits 0-4 quasi-bidirectional via window
// - Control three bit 2 routes pin 22
// - Control three bit 3 routes pin 23
// - Pulse duty per register, frequency by control two
// - Capture pin 0 rise raises maskable interrupt
// - Control zero bit 0 enables capture pin 0
// - Timer two clear needs control zero bits 3,5
// - Control zero bit 2 enables capture pin 1
// - Pin 25 clocks timer two when selected
// - Control one bit 4 drives event pin 4
// - Control zero bit 4 enables capture pin 2
// - Control one bit 6 drives event pin 5
// - Control zero bit 6 enables capture pin 3
// - Pins 26, 27 capture their own driven level
// - Pins 28, 29 always fast event outputs
module ptp_pin_select #(
  parameter int ADDR_W      = 8,
  parameter int STATE_TICKS = ptp_pkg::STATE_TIME_CYCLES
) (
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic [4:0]        portOnePinIn,
  output logic [4:0]             portOnePinOut,
  output logic [4:0]             portOnePinOe,
  input  wire logic              pin24In,
  input  wire logic              pin25In,
  input  wire logic              pin26In,
  output logic                   pin26Out,
  output logic                   pin26Oe,
  input  wire logic              pin27In,
  output logic                   pin27Out,
  output logic                   pin27Oe,
  output logic                   pin28Out,
  output logic                   pin29Out,
  input  wire logic [5:0]        fastEventIn,
  output logic [3:0]             captureLoad,
  output logic                   timerTwoClear,
  output logic                   timerTwoClockTick,
  output logic                   irq,
  output logic [15:0]            irqVector
);
  ////////////////////////////////////////////////////////////////////
  // Declarations
  logic [7:0]  ctl0_reg, ctl1_reg, ctl2_reg, ctl3_reg;
  logic [7:0]  duty1_reg, duty2_reg;
  logic [4:0]  portLatch_reg;
  logic [ptp_pkg::STATUS_W-1:0] status_reg, enable_reg, statusSet, statusClr;
  logic [ADDR_W-1:0] awAddr_reg;
  logic [31:0] wData_reg;
  logic [3:0]  wStrb_reg;
  logic        awHave_reg, wHave_reg;
  ptp_pkg::ptp_bus_e wState_reg, rState_reg;
  logic        doWrite;
  logic [7:0]  wByte;
  logic [31:0] rdValue;
  logic        rdHit;
  logic [8:0]  rawIn, sync1_reg, sync2_reg, sample_reg, rise_reg;
  logic [$clog2(STATE_TICKS+1)-1:0] tick_reg;
  logic        stateTick;
  logic        pwmFirst, pwmSecond;

  if (STATE_TICKS < 1 || ADDR_W < 8) begin : gChk
    $error("ptp_pin_select: bad STATE_TICKS or ADDR_W");
  end

  function automatic logic [7:0] mergeByte(input logic [7:0] old, input logic [31:0] d,
                                           input logic [3:0] s);
    mergeByte = s[0] ? d[7:0] : old;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel
  assign doWrite = awHave_reg && wHave_reg && (wState_reg == ptp_pkg::PTP_IDLE);
  assign wByte   = wData_reg[7:0];

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      awHave_reg    <= 1'b0;
      awAddr_reg    <= '0;
      s_axi_awready <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHave_reg    <= 1'b1;
      awAddr_reg    <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (doWrite) begin
      awHave_reg    <= 1'b0;
    end else begin
      s_axi_awready <= !awHave_reg && (wState_reg == ptp_pkg::PTP_IDLE);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wHave_reg    <= 1'b0;
      wData_reg    <= '0;
      wStrb_reg    <= '0;
      s_axi_wready <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHave_reg    <= 1'b1;
      wData_reg    <= s_axi_wdata;
      wStrb_reg    <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (doWrite) begin
      wHave_reg    <= 1'b0;
    end else begin
      s_axi_wready <= !wHave_reg && (wState_reg == ptp_pkg::PTP_IDLE);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wState_reg   <= ptp_pkg::PTP_IDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= ptp_pkg::RESP_OKAY;
    end else begin
      case (wState_reg)
        ptp_pkg::PTP_IDLE: begin
          if (doWrite) begin
            wState_reg   <= ptp_pkg::PTP_RESP;
            s_axi_bvalid <= 1'b1;
            case (awAddr_reg[7:0] & 8'hFC)
              ptp_pkg::ADDR_CTL0, ptp_pkg::ADDR_CTL1, ptp_pkg::ADDR_CTL2, ptp_pkg::ADDR_CTL3,
              ptp_pkg::ADDR_DUTY1, ptp_pkg::ADDR_DUTY2, ptp_pkg::ADDR_INT_CLEAR,
              ptp_pkg::ADDR_INT_ENABLE, ptp_pkg::ADDR_PORT1: s_axi_bresp <= ptp_pkg::RESP_OKAY;
              default: s_axi_bresp <= ptp_pkg::RESP_SLVERR;
            endcase
          end
        end
        ptp_pkg::PTP_RESP: begin
          if (s_axi_bready) begin
            wState_reg   <= ptp_pkg::PTP_IDLE;
            s_axi_bvalid <= 1'b0;
          end
        end
        default: wState_reg <= ptp_pkg::PTP_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Control registers
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ctl0_reg  <= ptp_pkg::IOC_RESET;
      ctl1_reg  <= ptp_pkg::IOC_RESET;
      ctl2_reg  <= ptp_pkg::IOC_RESET;
      ctl3_reg  <= ptp_pkg::IOC_RESET;
      duty1_reg <= ptp_pkg::DUTY_RESET;
      duty2_reg <= ptp_pkg::DUTY_RESET;
      enable_reg <= '0;
      portLatch_reg <= ptp_pkg::PORT1_RESET;
    end else if (doWrite) begin
      case (awAddr_reg[7:0] & 8'hFC)
        ptp_pkg::ADDR_CTL0:  ctl0_reg  <= mergeByte(ctl0_reg, wData_reg, wStrb_reg);
        ptp_pkg::ADDR_CTL1:  ctl1_reg  <= mergeByte(ctl1_reg, wData_reg, wStrb_reg);
        ptp_pkg::ADDR_CTL2:  ctl2_reg  <= mergeByte(ctl2_reg, wData_reg, wStrb_reg);
        ptp_pkg::ADDR_CTL3:  ctl3_reg  <= mergeByte(ctl3_reg, wData_reg, wStrb_reg);
        ptp_pkg::ADDR_DUTY1: duty1_reg <= mergeByte(duty1_reg, wData_reg, wStrb_reg);
        ptp_pkg::ADDR_DUTY2: duty2_reg <= mergeByte(duty2_reg, wData_reg, wStrb_reg);
        ptp_pkg::ADDR_INT_ENABLE: begin
          if (wStrb_reg[0]) begin
            enable_reg <= wByte[ptp_pkg::STATUS_W-1:0];
          end
        end
        ptp_pkg::ADDR_PORT1: begin
          if (wStrb_reg[0]) begin
            portLatch_reg <= wByte[4:0];
          end
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel
  always_comb begin
    rdValue = 32'h0000_0000;
    rdHit   = 1'b1;
    case (s_axi_araddr[7:0] & 8'hFC)
      ptp_pkg::ADDR_CTL0:       rdValue[7:0] = ctl0_reg;
      ptp_pkg::ADDR_CTL1:       rdValue[7:0] = ctl1_reg;
      ptp_pkg::ADDR_CTL2:       rdValue[7:0] = ctl2_reg;
      ptp_pkg::ADDR_CTL3:       rdValue[7:0] = ctl3_reg;
      ptp_pkg::ADDR_DUTY1:      rdValue[7:0] = duty1_reg;
      ptp_pkg::ADDR_DUTY2:      rdValue[7:0] = duty2_reg;
      ptp_pkg::ADDR_INT_STATUS: rdValue[ptp_pkg::STATUS_W-1:0] = status_reg;
      ptp_pkg::ADDR_INT_CLEAR:  rdValue = 32'h0000_0000;
      ptp_pkg::ADDR_INT_ENABLE: rdValue[ptp_pkg::STATUS_W-1:0] = enable_reg;
      ptp_pkg::ADDR_PIN_LEVEL:  rdValue[8:0] = sample_reg;
      ptp_pkg::ADDR_PORT1:      rdValue[4:0] = sample_reg[4:0];
      default:                  rdHit = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rState_reg    <= ptp_pkg::PTP_IDLE;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= ptp_pkg::RESP_OKAY;
    end else begin
      case (rState_reg)
        ptp_pkg::PTP_IDLE: begin
          s_axi_arready <= 1'b1;
          if (s_axi_arvalid && s_axi_arready) begin
            rState_reg    <= ptp_pkg::PTP_RESP;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rdValue;
            s_axi_rresp   <= rdHit ? ptp_pkg::RESP_OKAY : ptp_pkg::RESP_SLVERR;
          end
        end
        ptp_pkg::PTP_RESP: begin
          if (s_axi_rready) begin
            rState_reg   <= ptp_pkg::PTP_IDLE;
            s_axi_rvalid <= 1'b0;
          end
        end
        default: rState_reg <= ptp_pkg::PTP_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Pin sampling and edge detection
  // Shared pins 26/27 watch their own driven level when driving
  assign rawIn = {ctl1_reg[ptp_pkg::CTL1_EV5_EN] ? pin27Out : pin27In,
                  ctl1_reg[ptp_pkg::CTL1_EV4_EN] ? pin26Out : pin26In,
                  pin25In, pin24In, portOnePinIn};
  assign stateTick = (tick_reg == '0);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      tick_reg <= '0;
    end else if (stateTick) begin
      tick_reg <= ($bits(tick_reg))'(STATE_TICKS - 1);
    end else begin
      tick_reg <= tick_reg - 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sync1_reg  <= '0;
      sync2_reg  <= '0;
      sample_reg <= '0;
      rise_reg   <= '0;
    end else begin
      sync1_reg <= rawIn;
      sync2_reg <= sync1_reg;
      rise_reg  <= '0;
      if (stateTick) begin
        sample_reg <= sync2_reg;
        rise_reg   <= sync2_reg & ~sample_reg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Capture loads and timer 2 control
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      captureLoad       <= 4'h0;
      timerTwoClear     <= 1'b0;
      timerTwoClockTick <= 1'b0;
    end else begin
      captureLoad[0] <= rise_reg[5] && ctl0_reg[ptp_pkg::CTL0_CAP0_EN];
      captureLoad[1] <= rise_reg[6] && ctl0_reg[ptp_pkg::CTL0_CAP1_EN];
      captureLoad[2] <= rise_reg[7] && ctl0_reg[ptp_pkg::CTL0_CAP2_EN];
      captureLoad[3] <= rise_reg[8] && ctl0_reg[ptp_pkg::CTL0_CAP3_EN];
      timerTwoClear  <= rise_reg[5] && ctl0_reg[ptp_pkg::CTL0_T2CLR_A]
                        && ctl0_reg[ptp_pkg::CTL0_T2CLR_B];
      timerTwoClockTick <= rise_reg[6] && ctl0_reg[ptp_pkg::CTL0_T2TICK_EN]
                           && !ctl3_reg[ptp_pkg::CTL3_T2TICK_INT];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Interrupt status, enable and output
  always_comb begin
    statusSet = {rise_reg[5] && ctl0_reg[ptp_pkg::CTL0_T2CLR_A] && ctl0_reg[ptp_pkg::CTL0_T2CLR_B],
                 rise_reg[8:6], rise_reg[5]};
    statusClr = '0;
    if (doWrite && ((awAddr_reg[7:0] & 8'hFC) == ptp_pkg::ADDR_INT_CLEAR) && wStrb_reg[0]) begin
      statusClr = wByte[ptp_pkg::STATUS_W-1:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      status_reg <= '0;
      irq        <= 1'b0;
      irqVector  <= 16'h0000;
    end else begin
      status_reg <= (status_reg & ~statusClr) | statusSet;
      irq        <= |(status_reg & enable_reg);
      irqVector  <= (status_reg[ptp_pkg::ST_CAP0] && enable_reg[ptp_pkg::ST_CAP0])
                    ? ptp_pkg::CAP0_INT_VECTOR : 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Pulse outputs and pin drivers
  ptp_pwm #(.WIDTH(8)) uPwmFirst (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .duty     (duty1_reg),
    .slowMode (ctl2_reg[ptp_pkg::CTL2_PWM_SLOW]),
    .pwmOut   (pwmFirst)
  );

  ptp_pwm #(.WIDTH(8)) uPwmSecond (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .duty     (duty2_reg),
    .slowMode (ctl2_reg[ptp_pkg::CTL2_PWM_SLOW]),
    .pwmOut   (pwmSecond)
  );

  // Quasi pins pull low actively, high is left to the pull-up
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      portOnePinOut <= 5'h00;
      portOnePinOe  <= 5'h00;
    end else begin
      portOnePinOut       <= 5'h00;
      portOnePinOe        <= ~portLatch_reg;
      if (ctl3_reg[ptp_pkg::CTL3_PULSE1_SEL]) begin
        portOnePinOut[3] <= pwmFirst;
        portOnePinOe[3]  <= 1'b1;
      end
      if (ctl3_reg[ptp_pkg::CTL3_PULSE2_SEL]) begin
        portOnePinOut[4] <= pwmSecond;
        portOnePinOe[4]  <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pin26Out <= 1'b0;
      pin26Oe  <= 1'b0;
      pin27Out <= 1'b0;
      pin27Oe  <= 1'b0;
      pin28Out <= 1'b0;
      pin29Out <= 1'b0;
    end else begin
      pin26Out <= fastEventIn[4];
      pin26Oe  <= ctl1_reg[ptp_pkg::CTL1_EV4_EN];
      pin27Out <= fastEventIn[5];
      pin27Oe  <= ctl1_reg[ptp_pkg::CTL1_EV5_EN];
      pin28Out <= fastEventIn[0];
      pin29Out <= fastEventIn[1];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence seqCap0Rise;
    rise_reg[5] && enable_reg[ptp_pkg::ST_CAP0];
  endsequence
  sequence seqIrqUp;
    ##[1:2] irq;
  endsequence

  cap0_irq_a: assert property (seqCap0Rise |-> seqIrqUp)
    else $error("capture pin 0 rise did not raise irq");
  cap0_load_a: assert property (rise_reg[5] && ctl0_reg[0] |=> captureLoad[0])
    else $error("capture pin 0 load missing");
  t2_clear_gate_a: assert property (timerTwoClear |-> $past(ctl0_reg[3] && ctl0_reg[5] && rise_reg[5]))
    else $error("timer two clear without its enables");
  t2_clock_gate_a: assert property (timerTwoClockTick |-> $past(ctl0_reg[7] && !ctl3_reg[0]))
    else $error("timer two tick without its select");
  pulse_out_first_route_a: assert property ($past(ctl3_reg[2]) |-> portOnePinOe[3] && portOnePinOut[3] == $past(pwmFirst))
    else $error("pin 22 not carrying first pulse output");
  pulse_out_second_route_a: assert property ($past(ctl3_reg[3]) |-> portOnePinOe[4] && portOnePinOut[4] == $past(pwmSecond))
    else $error("pin 23 not carrying second pulse output");
  quasi_low_a: assert property (!portLatch_reg[0] |=> portOnePinOe[0] && !portOnePinOut[0])
    else $error("port 1 bit 0 not pulled low");
  ev4_drive_a: assert property ($past(ctl1_reg[4]) |-> pin26Oe && pin26Out == $past(fastEventIn[4]))
    else $error("pin 26 not driving event output 4");
  ev5_drive_a: assert property ($past(ctl1_reg[6]) |-> pin27Oe && pin27Out == $past(fastEventIn[5]))
    else $error("pin 27 not driving event output 5");
  dedicated_out_a: assert property (pin28Out == $past(fastEventIn[0]) && pin29Out == $past(fastEventIn[1]))
    else $error("pins 28/29 not following event outputs");
  tick_edge_a: assert property ((|rise_reg) |-> $past(stateTick))
    else $error("edge seen off the state time");
endmodule // ptp_pin_select
`default_nettype wire

// [hw/ptp_pkg.sv]
/*
  Constants for the port 1 / timing pin select block: register byte
  addresses, control field positions, reset values, timing counts.
  Assumes a 100 MHz core clock and an AXI4-Lite register bus.
*/
`default_nettype none
package ptp_pkg;
  ////////////////////////////////////////////////////////////////////
  // Register byte addresses
  localparam logic [7:0] ADDR_CTL0       = 8'h00;
  localparam logic [7:0] ADDR_CTL1       = 8'h04;
  localparam logic [7:0] ADDR_CTL2       = 8'h08;
  localparam logic [7:0] ADDR_CTL3       = 8'h0C;
  localparam logic [7:0] ADDR_DUTY1      = 8'h10;
  localparam logic [7:0] ADDR_DUTY2      = 8'h14;
  localparam logic [7:0] ADDR_INT_STATUS = 8'h18;
  localparam logic [7:0] ADDR_INT_CLEAR  = 8'h1C;
  localparam logic [7:0] ADDR_INT_ENABLE = 8'h20;
  localparam logic [7:0] ADDR_PIN_LEVEL  = 8'h24;
  localparam logic [7:0] PORT1_INDEX     = 8'h0F;
  localparam logic [7:0] ADDR_PORT1      = PORT1_INDEX << 2;
  ////////////////////////////////////////////////////////////////////
  // Control field positions
  localparam int CTL0_CAP0_EN    = 0;
  localparam int CTL0_CAP1_EN    = 2;
  localparam int CTL0_T2CLR_A    = 3;
  localparam int CTL0_CAP2_EN    = 4;
  localparam int CTL0_T2CLR_B    = 5;
  localparam int CTL0_CAP3_EN    = 6;
  localparam int CTL0_T2TICK_EN  = 7;
  localparam int CTL1_EV4_EN     = 4;
  localparam int CTL1_EV5_EN     = 6;
  localparam int CTL2_PWM_SLOW   = 2;
  localparam int CTL3_T2TICK_INT = 0;
  localparam int CTL3_PULSE1_SEL = 2;
  localparam int CTL3_PULSE2_SEL = 3;
  // Interrupt status layout
  localparam int ST_CAP0   = 0;
  localparam int ST_T2CLR  = 4;
  localparam int STATUS_W  = 5;
  ////////////////////////////////////////////////////////////////////
  // Reset values and fixed codes
  localparam logic [7:0] IOC_RESET   = 8'h00;
  localparam logic [7:0] DUTY_RESET  = 8'h00;
  localparam logic [4:0] PORT1_RESET = 5'h1F;
  localparam logic [7:0] CAP0_INT_NUMBER = 8'h04;
  localparam logic [15:0] CAP0_INT_VECTOR = 16'h2008;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  ////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS     = 10;
  localparam int STATE_TIME_NS     = 20;
  localparam int STATE_TIME_CYCLES = (STATE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CAP_HOLD_STATES   = 2;
  ////////////////////////////////////////////////////////////////////
  // Bus handshake states
  typedef enum logic [0:0] {
    PTP_IDLE = 1'b0,
    PTP_RESP = 1'b1
  } ptp_bus_e;
endpackage
`default_nettype wire

// [hw/ptp_pwm.sv]
/*
  Pulse-width generator: free counter compared against a duty value.
  Assumes duty and slowMode come from flops of the parent.
*/
`timescale 1ns/10ps
`default_nettype none
module ptp_pwm #(
  parameter int WIDTH = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] duty,
  input  wire logic             slowMode,
  output logic                  pwmOut
);
  logic [WIDTH-1:0] count_reg;
  logic             half_reg;

  if (WIDTH < 2) begin : gChk
    $error("ptp_pwm: WIDTH below 2");
  end

  // Slow mode halves the output frequency
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      half_reg <= 1'b0;
    end else begin
      half_reg <= ~half_reg;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      count_reg <= '0;
    end else if (!slowMode || half_reg) begin
      count_reg <= count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  // Duty sets the high share of each period
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pwmOut <= 1'b0;
    end else begin
      pwmOut <= (count_reg < duty);
    end
  end
endmodule // ptp_pwm
`default_nettype wire

// [verif/ptp_board_model.sv]
/*
  Board model: pull-ups on the port 1 pins, external drivers on pins 24-27.
  Assumes the bench sets the drive levels just after a clock edge.
*/
`timescale 1ns/10ps
`default_nettype none
module ptp_board_model (
  input  wire logic [4:0] portOnePinOut,
  input  wire logic [4:0] portOnePinOe,
  input  wire logic [4:0] pullLow,
  input  wire logic [3:0] pinDrv,
  input  wire logic       pin26Out,
  input  wire logic       pin26Oe,
  input  wire logic       pin27Out,
  input  wire logic       pin27Oe,
  output logic      [4:0] portOnePinIn,
  output logic            pin24In,
  output logic            pin25In,
  output logic            pin26In,
  output logic            pin27In
);
  // Released quasi pins float high unless the board pulls them down
  assign portOnePinIn = (portOnePinOe & portOnePinOut) | (~portOnePinOe & ~pullLow);
  assign pin24In      = pinDrv[0];
  assign pin25In      = pinDrv[1];
  // Shared pins: the device's own drive wins over the board
  assign pin26In      = pin26Oe ? pin26Out : pinDrv[2];
  assign pin27In      = pin27Oe ? pin27Out : pinDrv[3];
endmodule // ptp_board_model
`default_nettype wire

// [verif/testbench.sv]
/*
  Self-checking bench for the pin select block.
  Assumes the design answers AXI4-Lite requests and registers its outputs.
*/
`timescale 1ns/10ps
`default_nettype none
module testbench;
  typedef struct {logic [7:0] c0; logic [7:0] c3; int pin; logic [31:0] ex;} ptp_row_s;
  logic        sys_clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb, captureLoad, pinDrv;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [4:0]  portOnePinIn, portOnePinOut, portOnePinOe, pullLow;
  logic        pin24In, pin25In, pin26In, pin26Out, pin26Oe, pin27In, pin27Out, pin27Oe;
  logic        pin28Out, pin29Out, timerTwoClear, timerTwoClockTick, irq;
  logic [5:0]  fastEventIn;
  logic [15:0] irqVector;
  int          err_count, checks, cnt[6], base[6];
  ptp_row_s    rows[9] = '{'{8'h01, 8'h00, 0, 32'h100}, '{8'h28, 8'h00, 0, 32'h010},
    '{8'h08, 8'h00, 0, 32'h000}, '{8'h04, 8'h00, 1, 32'h100}, '{8'h80, 8'h00, 1, 32'h001},
    '{8'h80, 8'h01, 1, 32'h000}, '{8'h10, 8'h00, 2, 32'h100}, '{8'h40, 8'h00, 3, 32'h100},
    '{8'h00, 8'h00, 2, 32'h000}};

  ptp_pin_select #(.STATE_TICKS(2)) i_dut (.sys_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .portOnePinIn, .portOnePinOut, .portOnePinOe,
    .pin24In, .pin25In, .pin26In, .pin26Out, .pin26Oe, .pin27In, .pin27Out, .pin27Oe, .pin28Out,
    .pin29Out, .fastEventIn, .captureLoad, .timerTwoClear, .timerTwoClockTick, .irq, .irqVector);
  ptp_board_model i_board (.portOnePinOut, .portOnePinOe, .pullLow, .pinDrv, .pin26Out, .pin26Oe,
    .pin27Out, .pin27Oe, .portOnePinIn, .pin24In, .pin25In, .pin26In, .pin27In);

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Event pulse counters
  always @(posedge sys_clk) begin
    for (int i = 0; i < 4; i++) cnt[i] += captureLoad[i];
    cnt[4] += timerTwoClear;
    cnt[5] += timerTwoClockTick;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic pulse(input int i);
    @(posedge sys_clk);
    pinDrv[i] <= 1'b1; // Held four state times
    repeat (8) @(posedge sys_clk);
    pinDrv[i] <= 1'b0;
    repeat (12) @(posedge sys_clk);
  endtask
  task automatic rises(input int b, input logic [31:0] ex);
    int r;
    logic p;
    r = 0;
    @(posedge sys_clk);
    p = portOnePinOut[b];
    repeat (1024) begin
      @(posedge sys_clk);
      if (portOnePinOut[b] && !p) r++;
      p = portOnePinOut[b];
    end
    chk("pwm rises", 32'(r), ex);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (40000) @(posedge sys_clk);
    err_count++;
    end_of_test();
  end
  initial begin
    {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, pinDrv, pullLow, fastEventIn} = '0;
    s_axi_wstrb = 4'hF;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rdr(ptp_pkg::ADDR_CTL0);
    chk("ctl0", rd, 32'(ptp_pkg::IOC_RESET));
    rdr(ptp_pkg::ADDR_PORT1);
    chk("port1", rd, 32'h1F);
    rdr(8'h40);
    chk("unmapped", 32'(rsp), 32'(ptp_pkg::RESP_SLVERR));
    wr(8'h40, 32'h0000_00FF);
    chk("unmapped write", 32'(rsp), 32'(ptp_pkg::RESP_SLVERR));
    $display("reset test done");
    foreach (rows[k]) begin
      wr(ptp_pkg::ADDR_CTL0, 32'(rows[k].c0));
      wr(ptp_pkg::ADDR_CTL3, 32'(rows[k].c3));
      base = cnt;
      pulse(rows[k].pin);
      chk("events", 32'((cnt[rows[k].pin] - base[rows[k].pin]) * 256 + (cnt[4] - base[4]) * 16
        + cnt[5] - base[5]), rows[k].ex);
    end
    $display("row test done");
    wr(ptp_pkg::ADDR_CTL0, 32'h00);
    wr(ptp_pkg::ADDR_INT_CLEAR, 32'h1F);
    wr(ptp_pkg::ADDR_INT_ENABLE, 32'h01);
    pulse(0);
    chk("irq", 32'({irq, irqVector}), 32'h12008);
    wr(ptp_pkg::ADDR_INT_CLEAR, 32'h01);
    repeat (2) @(posedge sys_clk);
    chk("irq cleared", 32'({irq, irqVector}), 32'h0);
    wr(ptp_pkg::ADDR_INT_ENABLE, 32'h00);
    pulse(0);
    rdr(ptp_pkg::ADDR_INT_STATUS);
    chk("masked", 32'({irq, rd[4:0]}), 32'h01);
    $display("interrupt test done");
    wr(ptp_pkg::ADDR_PORT1, 32'h00);
    @(posedge sys_clk);
    chk("port1 oe", 32'(portOnePinOe), 32'h1F);
    wr(ptp_pkg::ADDR_PORT1, 32'h1F);
    pullLow <= 5'h04;
    repeat (8) @(posedge sys_clk);
    rdr(ptp_pkg::ADDR_PORT1);
    chk("port1 read", rd, 32'h1B);
    pullLow <= 5'h00;
    $display("port test done");
    wr(ptp_pkg::ADDR_DUTY1, 32'h40);
    wr(ptp_pkg::ADDR_DUTY2, 32'h80);
    wr(ptp_pkg::ADDR_CTL3, 32'h0C);
    @(posedge sys_clk);
    chk("pwm oe", 32'(portOnePinOe[4:3]), 32'h3);
    rises(3, 32'h4);
    rises(4, 32'h4);
    wr(ptp_pkg::ADDR_CTL2, 32'h04);
    rises(3, 32'h2);
    wr(ptp_pkg::ADDR_CTL3, 32'h00);
    repeat (2) @(posedge sys_clk);
    chk("quasi oe", 32'(portOnePinOe[4:3]), 32'h0);
    $display("pwm test done");
    fastEventIn <= 6'h33;
    wr(ptp_pkg::ADDR_CTL1, 32'h00);
    repeat (2) @(posedge sys_clk);
    chk("event pins", 32'({pin29Out, pin28Out, pin27Oe, pin26Oe}), 32'hC);
    wr(ptp_pkg::ADDR_CTL1, 32'h50);
    repeat (2) @(posedge sys_clk);
    chk("event drive", 32'({pin27Oe, pin27Out, pin26Oe, pin26Out}), 32'hF);
    fastEventIn <= 6'h00;
    wr(ptp_pkg::ADDR_CTL0, 32'h50);
    repeat (12) @(posedge sys_clk);
    base = cnt;
    fastEventIn <= 6'h30;
    repeat (16) @(posedge sys_clk);
    chk("self capture", 32'((cnt[2] - base[2]) * 16 + cnt[3] - base[3]), 32'h11);
    $display("event pin test done");
    rst_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rdr(ptp_pkg::ADDR_INT_STATUS);
    chk("reset state", 32'({pin27Oe, pin26Oe, irq, rd[4:0]}), 32'h0);
    $display("mid-run reset test done");
    end_of_test();
  end
endmodule // testbench
`default_nettype wire
